// ===== hw/ppf_defines.svh
// Constants for the port and pin-function multiplexer
//
// Contract
// [R1] Port 0 has five bits: 0 and 4 input only, 1 to 3 bidirectional.
// [R2] Ports 0 to 3 have per-bit pull-ups, active only for input bits.
// [R3] Analog use of port 1 needs input mode; pull-ups then turn off.
// [R4] Software sets clock control bit 6 before port 0 bit 4 is an input.
// [R5] Ports 8 and 9: eight-bit open-drain outputs, output after reset.
// [R6] Ports 10 to 12: eight-bit open-drain bidirectional, inputs after reset.
// [R7] Port 7: five-bit open-drain bidirectional, input after reset, no alternate.
// [R8] Three interrupt inputs detect chosen edges; the fourth falling only.
// [R9] Port 2 bits carry the two serial channels, strobe and busy.
// [R10] Serial bus lines share port 2 bits 5 and 6, bidirectional.
// [R11] Wide timer output on port 3 bit 0, byte timers on bits 1, 2.
// [R12] Timer count inputs: wide on port 0 bit 0, byte timers port 3.
// [R13] 53 display outputs: thirteen dedicated, forty on ports 8 to 12.
// [R14] Port 3 bit 5 gives selectable clock output, main or subsystem.
// [R15] Port 3 bit 6 gives buzzer output at three frequencies.
// [R16] Alternate output drives the pin instead of the latch while assigned.
`ifndef PPF_DEFINES_SVH
`define PPF_DEFINES_SVH

// Register groups, byte address bits [8:6]; slot in bits [5:2]
`define PPF_GRP_LATCH 3'h0
`define PPF_GRP_MODE 3'h1
`define PPF_GRP_ALT 3'h2
`define PPF_GRP_PULLUP 3'h3
`define PPF_GRP_PIN 3'h4
`define PPF_GRP_MISC 3'h5
`define PPF_NPORT 4'hA
`define PPF_NPULLUP 4'h4

// Slots inside the misc group
`define PPF_MISC_EDGE 4'h0
`define PPF_MISC_ANALOG 4'h1
`define PPF_MISC_CLKOUT 4'h2
`define PPF_MISC_BUZZER 4'h3

// Per-slot masks, slot 9 in the top byte
`define PPF_WIDTH_MASK 80'hFF_FF_FF_FF_FF_1F_FF_FF_FF_1F
`define PPF_INONLY_MASK 80'h00_00_00_00_00_00_00_00_00_11
`define PPF_DIRW_MASK 80'hFF_FF_FF_00_00_1F_FF_FF_FF_0E
`define PPF_ALT_MASK 80'hFF_FF_FF_FF_FF_00_7F_FF_00_00
`define PPF_MODE_RST 80'hFF_FF_FF_00_00_1F_FF_FF_FF_1F
`define PPF_ALT_DRIVE3 8'h67

// Display outputs
`define PPF_DISP_DED 13
`define PPF_DISP_FIRST_SLOT 5

// Clock control fields
`define PPF_CLKOUT_SUB 3
`define PPF_CLKOUT_EN 4
`define PPF_BUZ_EN 2
`define PPF_CLKOUT_HALF_SLOW 12'h080
`define PPF_CLKOUT_SEL_MAX 3'h5
`define PPF_BUZ_HALF_SLOW 12'h800
`define PPF_BUZ_SEL_MAX 2'h2

`endif

// ===== hw/ppf_pkg.sv
// Types shared by the port and pin-function multiplexer
package ppf_pkg;
    typedef logic [9:0][7:0] ppf_port_t;
    typedef enum logic [1:0] {PPF_CMOS, PPF_NCH_OD, PPF_PCH_OD} ppf_kind_e;
    // Signals coming from the on-chip peripherals
    typedef struct packed {
        logic [7:0] ser_out;
        logic [7:0] ser_drive;
        logic [2:0] timer_out;
        logic [52:0] disp;
    } ppf_periph_s;
    // Signals going to the on-chip peripherals
    typedef struct packed {
        logic [3:0] ext_irq;
        logic [2:0] count_in;
        logic [7:0] ser_in;
    } ppf_core_s;
endpackage

// ===== hw/ppf_tick_div.sv
`timescale 1ns/1ps
// Tick divider making the square wave for the clock and buzzer pins
module ppf_tick_div (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Divider setup
    input wire logic tick,
    input wire logic enable,
    input wire logic [11:0] half,
    // Square wave
    output logic wave
);
    logic [11:0] count;
    wire last;

    // Compare with >= so a smaller half after a change cannot run away
    assign last = (count >= half - 12'h001);

    // Disabled divider idles low so the pin stays quiet
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 12'h000;
            wave <= 1'b0;
        end else if (ce) begin
            if (!enable) begin
                count <= 12'h000;
                wave <= 1'b0;
            end else if (tick) begin
                count <= last ? 12'h000 : count + 12'h001;
                wave <= last ? ~wave : wave;
            end
        end
    end
endmodule

// ===== hw/ppf_pin_mux.sv
`timescale 1ns/1ps
`include "ppf_defines.svh"
// Port direction, pull-up and alternate-function multiplexer top
module ppf_pin_mux
    import ppf_pkg::*;
(
    // Clock, reset and clock enable
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_CE,
    // Register bus, Avalon-MM slave
    input wire logic [8:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // Clock sources for the clock and buzzer pins
    input wire logic I_MAIN_TICK,
    input wire logic I_SUB_CLK,
    // Peripheral side
    input wire ppf_periph_s I_PERIPH,
    output ppf_core_s O_CORE,
    // Port pins, slot order 0,1,2,3,7,8,9,10,11,12
    input wire ppf_port_t I_PORT_IN,
    output ppf_port_t O_PORT_OUT,
    output ppf_port_t O_PORT_OE_N,
    output logic [3:0][7:0] O_PORT_PU,
    // Dedicated display outputs
    output logic [12:0] O_DISP
);
    localparam logic [79:0] WMASK = `PPF_WIDTH_MASK;
    localparam logic [79:0] INONLY = `PPF_INONLY_MASK;
    localparam logic [79:0] DIRW = `PPF_DIRW_MASK;
    localparam logic [79:0] ALTM = `PPF_ALT_MASK;
    localparam logic [79:0] MODE_RST = `PPF_MODE_RST;

    // Address decode shared by the read and the write path
    function automatic logic reg_hit(input logic [2:0] g,
                                     input logic [3:0] i);
        reg_hit = ((g <= `PPF_GRP_ALT || g == `PPF_GRP_PIN)
                   && i < `PPF_NPORT)
               || ((g == `PPF_GRP_PULLUP || g == `PPF_GRP_MISC)
                   && i < `PPF_NPULLUP);
    endfunction

    // Pad behaviour of each slot
    function automatic ppf_kind_e slot_kind(input int s);
        if (s == 4) begin
            slot_kind = PPF_NCH_OD;
        end else if (s >= 5) begin
            slot_kind = PPF_PCH_OD;
        end else begin
            slot_kind = PPF_CMOS;
        end
    endfunction

    logic rst_meta;
    logic rst_n;
    logic [7:0] latch_q [10];
    logic [7:0] mode_q [10];
    logic [7:0] alt_q [10];
    logic [3:0][7:0] pu_q;
    logic [5:0] edge_q;
    logic analog_q;
    logic [4:0] clkout_q;
    logic [2:0] buz_q;
    logic [3:0] irq_prev;
    logic irq_armed;
    logic sub_q;
    wire [2:0] grp;
    wire [3:0] idx;
    wire [3:0] si;
    wire req;
    wire rd_hit;
    wire wr_go;
    wire [7:0] wd;
    wire [7:0] pin_byte;
    wire [7:0] misc_byte;
    wire [7:0] rd_byte;
    wire [3:0] rise;
    wire [3:0] fall;
    wire [2:0] rise_en;
    wire [2:0] fall_en;
    wire [3:0] irq_hit;
    wire [2:0] clk_sel;
    wire [1:0] buz_sel;
    wire div_wave;
    wire clk_wave;
    wire buz_wave;
    wire ppf_port_t next_out;
    wire ppf_port_t next_oe_n;
    wire [3:0][7:0] next_pu;
    ppf_core_s next_core;

    // Reset release through two flops; not gated by the clock enable
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Bus decode; address bits [1:0] are ignored
    assign grp = I_AVS_ADDRESS[8:6];
    assign idx = I_AVS_ADDRESS[5:2];
    assign si = (idx < `PPF_NPORT) ? idx : 4'h0;
    assign req = I_AVS_READ | I_AVS_WRITE;
    assign rd_hit = reg_hit(grp, idx);
    assign wr_go = I_AVS_WRITE & ~O_AVS_WAITREQUEST & I_AVS_BYTEENABLE[0]
                 & reg_hit(grp, idx) & (grp != `PPF_GRP_PIN);
    assign wd = I_AVS_WRITEDATA[7:0];

    // Read mux; unmapped addresses read zero
    assign pin_byte = I_PORT_IN[si] & WMASK[{si, 3'b000} +: 8];
    assign misc_byte =
        (idx == `PPF_MISC_EDGE) ? {2'b00, edge_q} :
        (idx == `PPF_MISC_ANALOG) ? {7'h00, analog_q} :
        (idx == `PPF_MISC_CLKOUT) ? {3'h0, clkout_q} :
        {5'h00, buz_q};
    assign rd_byte =
        !rd_hit ? 8'h00 :
        (grp == `PPF_GRP_LATCH) ? latch_q[si] :
        (grp == `PPF_GRP_MODE) ? mode_q[si] :
        (grp == `PPF_GRP_ALT) ? alt_q[si] :
        (grp == `PPF_GRP_PIN) ? pin_byte :
        (grp == `PPF_GRP_PULLUP) ? pu_q[si[1:0]] :
        misc_byte;

    // One wait state on every access keeps decode off the answer path
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= 32'h0000_0000;
        end else if (I_CE) begin
            O_AVS_WAITREQUEST <= ~(req & O_AVS_WAITREQUEST);
            if (I_AVS_READ && O_AVS_WAITREQUEST) begin
                O_AVS_READDATA <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Pull-up and misc control registers
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pu_q <= 32'h0000_0000;
            edge_q <= 6'h00;
            analog_q <= 1'b0;
            clkout_q <= 5'h00;
            buz_q <= 3'h0;
        end else if (I_CE && wr_go && grp == `PPF_GRP_PULLUP) begin
            pu_q[idx[1:0]] <= wd & WMASK[{idx[1:0], 3'b000} +: 8];
        end else if (I_CE && wr_go && grp == `PPF_GRP_MISC) begin
            if (idx == `PPF_MISC_EDGE) edge_q <= wd[5:0];
            if (idx == `PPF_MISC_ANALOG) analog_q <= wd[0];
            if (idx == `PPF_MISC_CLKOUT) clkout_q <= wd[4:0];
            if (idx == `PPF_MISC_BUZZER) buz_q <= wd[2:0];
        end
    end

    // External interrupt edges; armed after one sample so reset is quiet
    assign rise = I_PORT_IN[0][3:0] & ~irq_prev;
    assign fall = ~I_PORT_IN[0][3:0] & irq_prev;
    assign rise_en = {edge_q[4], edge_q[2], edge_q[0]};
    assign fall_en = {edge_q[5], edge_q[3], edge_q[1]};
    assign irq_hit = irq_armed ? {fall[3],                      // see [R8]
                     (rise[2:0] & rise_en) | (fall[2:0] & fall_en)} : 4'h0;

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_prev <= 4'h0;
            irq_armed <= 1'b0;
            sub_q <= 1'b0;
        end else if (I_CE) begin
            irq_prev <= I_PORT_IN[0][3:0];
            irq_armed <= 1'b1;
            sub_q <= I_SUB_CLK;
        end
    end

    // Clock output divider, slowest setting at select zero
    assign clk_sel = (clkout_q[2:0] > `PPF_CLKOUT_SEL_MAX)
                   ? `PPF_CLKOUT_SEL_MAX : clkout_q[2:0];
    assign buz_sel = (buz_q[1:0] > `PPF_BUZ_SEL_MAX)
                   ? `PPF_BUZ_SEL_MAX : buz_q[1:0];

    ppf_tick_div u_clk_div (
        .clk(I_CLK),
        .rst_n(rst_n),
        .ce(I_CE),
        .tick(I_MAIN_TICK),
        .enable(clkout_q[`PPF_CLKOUT_EN] & ~clkout_q[`PPF_CLKOUT_SUB]),
        .half(`PPF_CLKOUT_HALF_SLOW >> clk_sel),                 // see [R14]
        .wave(div_wave)
    );

    ppf_tick_div u_buz_div (
        .clk(I_CLK),
        .rst_n(rst_n),
        .ce(I_CE),
        .tick(I_MAIN_TICK),
        .enable(buz_q[`PPF_BUZ_EN]),
        .half(`PPF_BUZ_HALF_SLOW >> buz_sel),                    // see [R15]
        .wave(buz_wave)
    );

    // Subsystem source passes the sampled subsystem clock straight out
    assign clk_wave = clkout_q[`PPF_CLKOUT_EN]
                    & (clkout_q[`PPF_CLKOUT_SUB] ? sub_q : div_wave); // see [R14]

    // Per-slot registers and pad drive
    genvar gp;
    generate
        for (gp = 0; gp < 10; gp++) begin : g_slot
            localparam ppf_kind_e KIND = slot_kind(gp);
            wire sel;
            wire [7:0] wm;
            wire [7:0] av;
            wire [7:0] ad;
            wire [7:0] val;
            wire [7:0] drv;
            wire [7:0] oe;

            assign sel = wr_go && idx == 4'(gp);
            assign wm = WMASK[gp*8 +: 8];

            // Mode keeps the effective direction; fixed bits ignore writes
            always_ff @(posedge I_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    latch_q[gp] <= 8'h00;
                    mode_q[gp] <= MODE_RST[gp*8 +: 8];   // see [R5] [R6] [R7]
                    alt_q[gp] <= 8'h00;
                end else if (I_CE && sel) begin
                    if (grp == `PPF_GRP_LATCH) latch_q[gp] <= wd & wm;
                    if (grp == `PPF_GRP_MODE) begin
                        mode_q[gp] <= (wd & DIRW[gp*8 +: 8])  // see [R1]
                                    | INONLY[gp*8 +: 8];      // see [R4]
                    end
                    if (grp == `PPF_GRP_ALT) begin
                        alt_q[gp] <= wd & ALTM[gp*8 +: 8];    // see [R7]
                    end
                end
            end

            // Alternate sources per slot
            if (gp == 2) begin : g_ser
                assign av = I_PERIPH.ser_out;           // see [R9] [R10]
                assign ad = I_PERIPH.ser_drive;
            end else if (gp == 3) begin : g_tmr
                assign av = {1'b0, buz_wave, clk_wave, 2'b00,
                             I_PERIPH.timer_out};       // see [R11]
                assign ad = `PPF_ALT_DRIVE3;
            end else if (gp >= `PPF_DISP_FIRST_SLOT) begin : g_disp
                assign av = I_PERIPH.disp[`PPF_DISP_DED
                    + (gp - `PPF_DISP_FIRST_SLOT) * 8 +: 8]; // see [R13]
                assign ad = 8'hFF;
            end else begin : g_none
                assign av = 8'h00;
                assign ad = 8'h00;
            end

            // Alternate function owns the pin while selected
            assign val = (alt_q[gp] & av) | (~alt_q[gp] & latch_q[gp]); // see [R16]
            assign drv = ((alt_q[gp] & ad) | (~alt_q[gp] & ~mode_q[gp]))
                       & wm & ~INONLY[gp*8 +: 8];       // see [R16] [R1]

            // Open-drain pads drive only their active level
            if (KIND == PPF_NCH_OD) begin : g_nch
                assign oe = drv & ~val;                 // see [R7]
                assign next_out[gp] = 8'h00;
            end else if (KIND == PPF_PCH_OD) begin : g_pch
                assign oe = drv & val;                  // see [R5] [R6]
                assign next_out[gp] = wm;
            end else begin : g_cmos
                assign oe = drv;
                assign next_out[gp] = val;
            end
            assign next_oe_n[gp] = ~oe;

            // Pull-up only while the bit is not driven
            if (gp < 4) begin : g_pu
                assign next_pu[gp] = pu_q[gp] & ~drv & wm   // see [R2]
                    & ((gp == 1) ? {8{~analog_q}} : 8'hFF); // see [R3]
            end
        end
    endgenerate

    // Inputs handed to the peripherals
    assign next_core = '{
        ext_irq: irq_hit,
        count_in: {I_PORT_IN[3][4], I_PORT_IN[3][3],
                   I_PORT_IN[0][0]},                    // see [R12]
        ser_in: I_PORT_IN[2] & alt_q[2]                 // see [R9]
    };

    // Every pin-side output leaves from a flop
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_PORT_OUT <= 80'h0000_0000_0000_0000_0000;
            O_PORT_OE_N <= 80'hFFFF_FFFF_FFFF_FFFF_FFFF;
            O_PORT_PU <= 32'h0000_0000;
            O_DISP <= 13'h0000;
            O_CORE <= ppf_core_s'(15'h0000);
        end else if (I_CE) begin
            O_PORT_OUT <= next_out;
            O_PORT_OE_N <= next_oe_n;
            O_PORT_PU <= next_pu;
            O_DISP <= I_PERIPH.disp[12:0];              // see [R13]
            O_CORE <= next_core;
        end
    end
endmodule

// ===== sim/ppf_pin_mux_asserts.sv
`timescale 1ns/1ps
// Concurrent checks on the pin multiplexer top ports
module ppf_pin_mux_asserts
    import ppf_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_CE,
    // Register bus
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    // Pins and peripherals
    input wire ppf_periph_s I_PERIPH,
    input wire ppf_core_s O_CORE,
    input wire ppf_port_t I_PORT_IN,
    input wire ppf_port_t O_PORT_OUT,
    input wire ppf_port_t O_PORT_OE_N,
    input wire logic [3:0][7:0] O_PORT_PU,
    input wire logic [12:0] O_DISP
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    logic [1:0] up_cnt;
    wire live = (up_cnt == 2'h3);
    // Internal reset trails the pin by two edges and outputs load one edge later, so skip three cycles
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) up_cnt <= 2'h0;
        else if (!live) up_cnt <= up_cnt + 2'h1;
    end
    // Bus request seen, then exactly one low cycle of waitrequest
    sequence bus_first;
        (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
    endsequence
    sequence bus_answer;
        !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
    endsequence
    a_bus_one_wait: assert property (bus_first |=> bus_answer)
        else $error("bus answer not after one wait state");
    a_rdata_upper: assert property (O_AVS_READDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_pull_only_input: assert property (
        (O_PORT_PU & ~O_PORT_OE_N[3:0]) == 32'h0)
        else $error("pull-up on a driven pin");
    a_inonly_bits: assert property (
        (O_PORT_OE_N[0] | 8'h0E) == 8'hFF)
        else $error("input-only bit driven");
    a_nch_drive: assert property (
        O_PORT_OUT[4] == 8'h00 && O_PORT_OE_N[4][7:5] == 3'h7)
        else $error("open-drain low port misdriven");
    a_pch_level: assert property (
        live |-> O_PORT_OUT[9:5] == 40'hFF_FFFF_FFFF)
        else $error("open-drain high port level wrong");
    // A frozen clock enable holds outputs, so gate on the updating edge
    a_irq3_fall: assert property (
        O_CORE.ext_irq[3] && $past(I_CE) |-> !$past(I_PORT_IN[0][3]))
        else $error("fourth interrupt without falling edge");
    a_irq_pulse: assert property (
        O_CORE.ext_irq[0] && I_CE |=> !O_CORE.ext_irq[0])
        else $error("interrupt pulse too long");
    a_disp_follow: assert property (
        live && $past(I_CE) |-> O_DISP == $past(I_PERIPH.disp[12:0]))
        else $error("dedicated display outputs wrong");
    a_count_in: assert property (
        live && $past(I_CE) |-> O_CORE.count_in ==
        $past({I_PORT_IN[3][4], I_PORT_IN[3][3], I_PORT_IN[0][0]}))
        else $error("count input routing wrong");
endmodule

bind ppf_pin_mux ppf_pin_mux_asserts chk_u (.I_CLK, .I_ARST_N, .I_CE,
    .I_AVS_READ, .I_AVS_WRITE, .O_AVS_READDATA, .O_AVS_WAITREQUEST,
    .I_PERIPH, .O_CORE, .I_PORT_IN, .O_PORT_OUT, .O_PORT_OE_N,
    .O_PORT_PU, .O_DISP);

// ===== sim/ppf_board_model.sv
`timescale 1ns/1ps
// Board model resolving the level of every port pin
module ppf_board_model
    import ppf_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Device drive
    input wire ppf_port_t i_out,
    input wire ppf_port_t i_oe_n,
    input wire logic [3:0][7:0] i_pu,
    // Board drive
    input wire ppf_port_t i_ext,
    input wire ppf_port_t i_ext_en,
    // Resolved levels
    output ppf_port_t o_pin
);
    ppf_port_t last;
    // Device wins, then board; a loose pin without pull-up keeps flipping
    always_comb begin
        for (int s = 0; s < 10; s++) begin
            for (int b = 0; b < 8; b++) begin
                if (!i_oe_n[s][b]) o_pin[s][b] = i_out[s][b];
                else if (i_ext_en[s][b]) o_pin[s][b] = i_ext[s][b];
                else if (s < 4 && i_pu[s % 4][b]) o_pin[s][b] = 1'b1;
                else o_pin[s][b] = ~last[s][b];
            end
        end
    end
    // Previous level, so a released line never reads as held
    always_ff @(posedge i_clk) last <= o_pin;
endmodule

// ===== sim/ppf_pin_mux_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the pin multiplexer
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
    bad_count++; \
    $display("unexpected %0t got %0h want %0h", $time, (a), (e)); end end
module ppf_pin_mux_tb;
    import ppf_pkg::*;
    typedef struct {logic [8:0] a; logic w; logic [7:0] d;} ppf_row_s;
    logic clk, arst_n, rd, wr, tick, wait_o, ce, sub;
    logic [8:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [3:0] be;
    logic [3:0][7:0] pu;
    logic [12:0] disp;
    logic [52:0] dpat;
    ppf_periph_s periph;
    ppf_core_s core;
    ppf_port_t pin, pout, oe_n, ext, ext_en;
    int bad_count, comparisons, n5, n6;
    int irq_n [4];
    int irq_x [4] = '{2, 1, 1, 1};
    // Register rows: reset values, forced bits, refused places
    ppf_row_s rows [11] = '{'{9'h050, 0, 8'h1F}, '{9'h054, 0, 8'h00},
        '{9'h05C, 0, 8'hFF}, '{9'h040, 1, 8'h00}, '{9'h040, 0, 8'h11},
        '{9'h054, 1, 8'hFF}, '{9'h054, 0, 8'h00}, '{9'h090, 1, 8'hFF},
        '{9'h090, 0, 8'h00}, '{9'h17C, 1, 8'h55}, '{9'h17C, 0, 8'h00}};

    ppf_pin_mux dut_u (.I_CLK(clk), .I_ARST_N(arst_n), .I_CE(ce),
        .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(be),
        .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wait_o),
        .I_MAIN_TICK(tick), .I_SUB_CLK(sub), .I_PERIPH(periph),
        .O_CORE(core), .I_PORT_IN(pin), .O_PORT_OUT(pout),
        .O_PORT_OE_N(oe_n), .O_PORT_PU(pu), .O_DISP(disp));
    ppf_board_model brd_u (.i_clk(clk), .i_out(pout), .i_oe_n(oe_n),
        .i_pu(pu), .i_ext(ext), .i_ext_en(ext_en), .o_pin(pin));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Interrupt pulse counter
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) if (core.ext_irq[i] === 1'b1) irq_n[i]++;
    end
    // One bus transfer; holds everything until waitrequest is seen low
    task automatic bus(input logic w, input logic [8:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= {24'h0, d};
        // No local limit here: only the watchdog ends a hung handshake
        do begin
            @(posedge clk);
        end while (wait_o !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Pins lag writes by an edge and inputs by one more
    task settle;
        repeat (3) @(negedge clk);
    endtask
    task test_done;
        $display("checks %0d errors %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (10000) @(posedge clk);
        bad_count++;
        test_done;
    end
    // Main sequence
    initial begin
        {arst_n, rd, wr, tick, sub, adr, wdat, periph, ext} = '0;
        ce = 1'b1;
        be = 4'hF;
        ext_en = '1;
        dpat = 53'h1A_5A5A_C3C3_0F0F;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) begin
                `CHK(q, {24'h0, rows[i].d})
            end
        end
        be <= 4'h0;
        bus(1, 9'h004, 8'hFF);
        be <= 4'hF;
        bus(0, 9'h004, 8'h00);
        `CHK(q[7:0], 8'h00)
        // Pull-ups on port 1, then drive bit 0, then analog use
        ext_en[1] <= 8'h00;
        bus(1, 9'h0C4, 8'hFF);
        settle;
        `CHK(pu[1], 8'hFF)
        bus(1, 9'h044, 8'hFE);
        settle;
        `CHK(pu[1], 8'hFE)
        `CHK(oe_n[1], 8'hFE)
        bus(0, 9'h104, 8'h00);
        `CHK(q[7:0], 8'hFE)
        // Analog use asks for port 1 back in input mode first
        bus(1, 9'h044, 8'hFF);
        bus(1, 9'h144, 8'h01);
        settle;
        `CHK(pu[1], 8'h00)
        // Count inputs, then edge selection of the interrupts
        @(posedge clk);
        ext[0] <= 8'h01;
        ext[3] <= 8'h10;
        settle;
        `CHK(core.count_in, 3'b101)
        // Port 0 bits 1 to 3 were left driving low; release them
        bus(1, 9'h040, 8'h1F);
        bus(1, 9'h140, 8'h27);
        @(posedge clk);
        ext[0] <= 8'h00;
        repeat (6) @(negedge clk);
        irq_n = '{0, 0, 0, 0};
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            ext[0][3:0] <= k ? 4'h0 : 4'hF;
            repeat (6) @(posedge clk);
        end
        foreach (irq_n[i]) `CHK(irq_n[i], irq_x[i])
        // Port 3 timer, clock and buzzer functions
        periph.timer_out <= 3'b101;
        tick <= 1'b1;
        bus(1, 9'h04C, 8'h00);
        bus(1, 9'h08C, 8'h67);
        bus(1, 9'h148, 8'h15);
        bus(1, 9'h14C, 8'h07);
        settle;
        `CHK(pout[3][2:0], 3'b101)
        `CHK(oe_n[3][2:0], 3'b000)
        // Buzzer select 3 is out of range and falls back to half 512
        {n5, n6} = '0;
        repeat (2048) begin
            @(negedge clk);
            n5 += int'(pout[3][5] !== brd_u.last[3][5]);
            n6 += int'(pout[3][6] !== brd_u.last[3][6]);
        end
        `CHK(n5 inside {[511:513]}, 1'b1)
        `CHK(n6 inside {[3:5]}, 1'b1)
        // Clock enable low freezes the pins
        @(posedge clk);
        ce <= 1'b0;
        periph.timer_out <= 3'b010;
        settle;
        `CHK(pout[3][2:0], 3'b101)
        @(posedge clk);
        ce <= 1'b1;
        settle;
        `CHK(pout[3][2:0], 3'b010)
        // Subsystem source passes its level to the clock pin
        bus(1, 9'h148, 8'h18);
        sub <= 1'b1;
        settle;
        `CHK(pout[3][5], 1'b1)
        @(posedge clk);
        sub <= 1'b0;
        settle;
        `CHK(pout[3][5], 1'b0)
        bus(1, 9'h08C, 8'h00);
        settle;
        `CHK(pout[3][2:0], 3'b000)
        // Serial lines on port 2
        periph.ser_out <= 8'hA5;
        periph.ser_drive <= 8'h0F;
        ext[2] <= 8'hC0;
        bus(1, 9'h088, 8'hFF);
        settle;
        `CHK(pout[2][3:0], 4'h5)
        `CHK(oe_n[2], 8'hF0)
        `CHK(core.ser_in, 8'hC5)
        // Display outputs over ports 8 to 12
        periph.disp <= dpat;
        for (int s = 5; s < 10; s++) bus(1, 9'h080 + 9'(4 * s), 8'hFF);
        settle;
        `CHK(disp, dpat[12:0])
        for (int s = 5; s < 10; s++) begin
            `CHK(oe_n[s], ~dpat[8*s-27 +: 8])
        end
        // Reset in mid-run
        @(posedge clk);
        arst_n <= 1'b0;
        @(negedge clk);
        `CHK(oe_n, {10{8'hFF}})
        `CHK(wait_o, 1'b1)
        @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(0, 9'h05C, 8'h00);
        `CHK(q[7:0], 8'hFF)
        bus(0, 9'h088, 8'h00);
        `CHK(q[7:0], 8'h00)
        test_done;
    end
endmodule
